// ---- pic_pkg.sv ----
// Shared constants and types of the prioritized interrupt controller
package pic_pkg;

  // ----------------------------------------------------------------
  // Source numbering
  // ----------------------------------------------------------------
  localparam int          PIC_NSRC    = 48;      // Latch vector width
  localparam int          PIC_SRC_W   = 6;       // Source index width
  localparam logic [5:0]  PIC_SRC_WDT = 6'h02;   // Watchdog latch
  localparam logic [5:0]  PIC_SRC_PIN = 6'h03;   // External pin latch
  // Latches that real sources drive; reserved positions stay zero
  localparam logic [47:0] PIC_SRC_MASK = 48'h005f_0555_154c;
  // Maskable sources only (watchdog excluded)
  localparam logic [47:0] PIC_SEN_MASK = 48'h005f_0555_1548;

  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------
  localparam logic [19:0] PIC_VEC_RESET = 20'hffffc; // Level 0
  localparam logic [19:0] PIC_VEC_SWI   = 20'hffff8; // Software trap
  localparam logic [19:0] PIC_VEC_HIGH  = 20'hffffc; // Base, levels 0-31
  localparam logic [19:0] PIC_VEC_LOW   = 20'hfff3c; // Base, levels 32+
  localparam logic [5:0]  PIC_LOW_FIRST = 6'h20;     // First low level

  // ----------------------------------------------------------------
  // Special-function byte offsets (device side)
  // ----------------------------------------------------------------
  localparam logic [7:0] PIC_A_IL0 = 8'h3c; // Latches 0-7
  localparam logic [7:0] PIC_A_IL1 = 8'h3d; // Latches 8-15
  localparam logic [7:0] PIC_A_IL2 = 8'h2e; // Latches 16-23
  localparam logic [7:0] PIC_A_IL3 = 8'h2f; // Latches 24-31
  localparam logic [7:0] PIC_A_IL4 = 8'h2b; // Latches 32-39
  localparam logic [7:0] PIC_A_EF0 = 8'h3a; // Enables 0-7, bit 0 global
  localparam logic [7:0] PIC_A_EF1 = 8'h3b; // Enables 8-15
  localparam logic [7:0] PIC_A_EF2 = 8'h2c; // Enables 16-23
  localparam logic [7:0] PIC_A_EF3 = 8'h2d; // Enables 24-31
  localparam logic [7:0] PIC_A_EF4 = 8'h2a; // Enables 32-39
  localparam logic [7:0] PIC_A_CTL = 8'h39; // Pin, watchdog, nesting

  // Control byte fields
  localparam int         PIC_CTL_PIN = 0;     // Pin interrupt enable
  localparam int         PIC_CTL_WDS = 1;     // Watchdog output select
  localparam int         PIC_CTL_NST = 4;     // Nesting counter, 2 bits
  localparam logic       PIC_WDS_RST = 1'b1;  // Reset value: reset request
  localparam logic [1:0] PIC_NST_CLR = 2'h1;  // Write code: clear
  localparam logic [1:0] PIC_NST_DEC = 2'h2;  // Write code: count down

  // ----------------------------------------------------------------
  // Avalon register map of the CPU end (word addresses)
  // ----------------------------------------------------------------
  localparam logic [1:0] PIC_AV_SFR  = 2'h0; // Byte access command
  localparam logic [1:0] PIC_AV_CPU  = 2'h1; // Acceptance sequencing
  localparam logic [1:0] PIC_AV_STAT = 2'h2; // Request status
  localparam int         PIC_SFR_RD  = 16;   // Read-not-write bit
  localparam int         PIC_CPU_ACC = 0;    // Accept presented source
  localparam int         PIC_CPU_RTI = 1;    // Maskable return
  localparam int         PIC_CPU_RTN = 2;    // Non-maskable return
  localparam int         PIC_CPU_GIE = 3;    // Stacked enable for return
  localparam int         PIC_CPU_SWI = 4;    // Software trap entry

  typedef enum logic [1:0] {PIC_IDLE, PIC_BUSY, PIC_DONE} pic_state_t;

endpackage : pic_pkg

// ---- pic_if.sv ----
// Link between interrupt controller and CPU core
`timescale 1ns/1ps
`default_nettype none
interface pic_if;
  logic [7:0]  sfr_addr;   // Special-function byte offset
  logic [7:0]  sfr_wdata;  // Write byte
  logic        sfr_wr;     // Byte write strobe
  logic        sfr_rd;     // Byte read strobe
  logic [7:0]  sfr_rdata;  // Read byte
  logic        sfr_rvalid; // Read byte valid
  logic        irq_req;    // A source awaits acceptance
  logic [5:0]  irq_src;    // Winning source number
  logic [19:0] irq_vec;    // Winning vector address
  logic        saved_gie;  // Global enable as it stood at entry
  logic        accept;     // CPU takes presented source
  logic        swi_take;   // CPU enters software trap
  logic        ret_mask;   // Maskable return executed
  logic        ret_nmi;    // Non-maskable return executed
  logic        ret_nmi_gie; // Stacked enable popped by that return

  modport dev (input sfr_addr, sfr_wdata, sfr_wr, sfr_rd, accept,
               swi_take, ret_mask, ret_nmi, ret_nmi_gie,
               output sfr_rdata, sfr_rvalid, irq_req, irq_src, irq_vec,
               saved_gie);
  modport cpu (output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, accept,
               swi_take, ret_mask, ret_nmi, ret_nmi_gie,
               input sfr_rdata, sfr_rvalid, irq_req, irq_src, irq_vec,
               saved_gie);
endinterface : pic_if
`default_nettype wire

// ---- pic_dev.sv ----
// Interrupt controller: latches, enables, priority and vectors
`timescale 1ns/1ps
`default_nettype none

module pic_dev
  import pic_pkg::*;
(
  input  wire logic        clk_i,            // System clock
  input  wire logic        rst_n_i,          // Any device reset
  input  wire logic [47:0] src_evt_i,        // Peripheral request pulses
  input  wire logic        watchdog_irq_i,   // Watchdog overflow pulse
  input  wire logic        external_pin_irq_i, // Asynchronous pin
  output logic             wdt_reset_req_o,  // Watchdog reset request
  pic_if.dev               bus               // CPU side
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [47:0] pend;      // Pending latches
    logic [47:0] sen;       // Individual enables
    logic        gie;       // Global enable
    logic        pin_en;    // Pin interrupt enable
    logic        wds;       // Watchdog output select
    logic [1:0]  nest;      // Nesting counter
    logic        pin_s1;    // Pin synchroniser, first stage
    logic        pin_s2;    // Pin synchroniser, second stage
    logic        pin_d;     // Previous synchronised pin level
    logic [7:0]  rdata;     // Read byte
    logic        rvalid;    // Read byte valid
    logic        irq_req;   // Presented request
    logic [5:0]  src;       // Presented source
    logic [19:0] vec;       // Presented vector
    logic        saved_gie; // Stacked global enable
    logic        wdt_rst;   // Watchdog reset pulse
  } pic_dev_t;

  pic_dev_t st_reg;  // Registered state
  pic_dev_t st_next; // Next state

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Vector of a level: two linear runs with a gap between them
  function automatic logic [19:0] pic_vec_of(input logic [5:0] s);
    if (s < PIC_LOW_FIRST) begin
      pic_vec_of = PIC_VEC_HIGH - {12'h000, s, 2'b00};
    end else begin
      pic_vec_of = PIC_VEC_LOW - {12'h000, s - PIC_LOW_FIRST, 2'b00};
    end
  endfunction

  // Byte group of a latch offset, 7 when none
  function automatic logic [2:0] pic_lat_grp(input logic [7:0] a);
    case (a)
      PIC_A_IL0: pic_lat_grp = 3'h0;
      PIC_A_IL1: pic_lat_grp = 3'h1;
      PIC_A_IL2: pic_lat_grp = 3'h2;
      PIC_A_IL3: pic_lat_grp = 3'h3;
      PIC_A_IL4: pic_lat_grp = 3'h4;
      default:   pic_lat_grp = 3'h7;
    endcase
  endfunction

  // Byte group of an enable offset, 7 when none
  function automatic logic [2:0] pic_sen_grp(input logic [7:0] a);
    case (a)
      PIC_A_EF0: pic_sen_grp = 3'h0;
      PIC_A_EF1: pic_sen_grp = 3'h1;
      PIC_A_EF2: pic_sen_grp = 3'h2;
      PIC_A_EF3: pic_sen_grp = 3'h3;
      PIC_A_EF4: pic_sen_grp = 3'h4;
      default:   pic_sen_grp = 3'h7;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [47:0] set_v;   // Latches raised this cycle
    logic [47:0] clr_v;   // Latches cleared this cycle
    logic [47:0] ok_v;    // Pending and allowed
    logic [2:0]  ig;      // Latch group addressed
    logic [2:0]  eg;      // Enable group addressed
    logic [5:0]  win;     // Lowest allowed source
    st_next        = st_reg;
    st_next.rvalid = 1'b0;
    set_v          = '0;
    clr_v          = '0;
    ok_v           = '0;
    win            = '0;
    ig             = pic_lat_grp(bus.sfr_addr);
    eg             = pic_sen_grp(bus.sfr_addr);

    // Pin synchroniser; only the second stage feeds logic
    st_next.pin_s1 = external_pin_irq_i;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.pin_d  = st_reg.pin_s2;

    // Request capture; reserved positions are dropped
    set_v = src_evt_i & PIC_SRC_MASK;
    set_v[PIC_SRC_WDT] = watchdog_irq_i & ~st_reg.wds;
    set_v[PIC_SRC_PIN] = st_reg.pin_s2 & ~st_reg.pin_d;
    // Select at one turns the watchdog into a reset request
    st_next.wdt_rst = watchdog_irq_i & st_reg.wds;

    // Software writes
    if (bus.sfr_wr) begin
      if (ig != 3'h7) begin
        // A zero bit clears that latch; a one changes nothing
        clr_v[{ig, 3'b000} +: 8] = ~bus.sfr_wdata;
      end
      if (eg != 3'h7) begin
        st_next.sen[{eg, 3'b000} +: 8] = bus.sfr_wdata;
      end
      if (bus.sfr_addr == PIC_A_EF0) begin
        st_next.gie = bus.sfr_wdata[0];
      end
      if (bus.sfr_addr == PIC_A_CTL) begin
        st_next.pin_en = bus.sfr_wdata[PIC_CTL_PIN];
        st_next.wds    = bus.sfr_wdata[PIC_CTL_WDS];
        case (bus.sfr_wdata[PIC_CTL_NST +: 2])
          PIC_NST_CLR: st_next.nest = 2'h0;
          PIC_NST_DEC: st_next.nest = st_reg.nest - 2'h1;
          default:     st_next.nest = st_reg.nest; // Reserved codes
        endcase
      end
    end
    st_next.sen = st_next.sen & PIC_SEN_MASK;

    // Acceptance: stack enable, drop it, count one level deeper
    if (bus.accept && st_reg.irq_req) begin
      clr_v[st_reg.src] = 1'b1;
    end
    if ((bus.accept && st_reg.irq_req) || bus.swi_take) begin
      st_next.saved_gie = st_reg.gie;
      st_next.gie       = 1'b0;
      st_next.nest      = st_reg.nest + 2'h1;
    end else if (bus.ret_mask) begin
      st_next.gie  = 1'b1;
      st_next.nest = st_reg.nest - 2'h1;
    end else if (bus.ret_nmi) begin
      // Enable comes back as the stacked bit the CPU pops with the return
      st_next.gie  = bus.ret_nmi_gie;
      st_next.nest = st_reg.nest - 2'h1;
    end

    // Set wins over clear so a request in a clearing cycle survives
    st_next.pend = ((st_reg.pend & ~clr_v) | set_v) & PIC_SRC_MASK;

    // Allowed sources: watchdog ignores enables, others need both
    ok_v = st_reg.pend & st_reg.sen & {48{st_reg.gie}};
    ok_v[PIC_SRC_PIN] = ok_v[PIC_SRC_PIN] & st_reg.pin_en;
    ok_v[PIC_SRC_WDT] = st_reg.pend[PIC_SRC_WDT];
    // Highest index first so the lowest number is left standing
    for (int i = PIC_NSRC - 1; i >= 0; i--) begin
      if (ok_v[i]) begin
        win = 6'(i);
      end
    end
    st_next.irq_req = (|ok_v) & ~bus.accept;
    st_next.src     = win;
    st_next.vec     = pic_vec_of(win);

    // Read path, one cycle behind the strobe
    if (bus.sfr_rd) begin
      st_next.rvalid = 1'b1;
      if (ig != 3'h7) begin
        st_next.rdata = st_reg.pend[{ig, 3'b000} +: 8];
      end else if (bus.sfr_addr == PIC_A_EF0) begin
        st_next.rdata = {st_reg.sen[7:1], st_reg.gie};
      end else if (eg != 3'h7) begin
        st_next.rdata = st_reg.sen[{eg, 3'b000} +: 8];
      end else if (bus.sfr_addr == PIC_A_CTL) begin
        st_next.rdata = {2'b00, st_reg.nest, 2'b00,
                         st_reg.wds, st_reg.pin_en};
      end else begin
        st_next.rdata = 8'h00; // Unmapped offsets read zero
      end
    end
  end

  // ----------------------------------------------------------------
  // State register; reset clears latches, enables and counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg     <= '0;
      st_reg.wds <= PIC_WDS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from state
  // ----------------------------------------------------------------
  assign bus.sfr_rdata    = st_reg.rdata;
  assign bus.sfr_rvalid   = st_reg.rvalid;
  assign bus.irq_req      = st_reg.irq_req;
  assign bus.irq_src      = st_reg.src;
  assign bus.irq_vec      = st_reg.vec;
  assign bus.saved_gie    = st_reg.saved_gie;
  assign wdt_reset_req_o  = st_reg.wdt_rst;

endmodule : pic_dev
`default_nettype wire

// ---- pic_cpu.sv ----
// CPU end: Avalon register front for acceptance and byte access
`timescale 1ns/1ps
`default_nettype none
module pic_cpu
  import pic_pkg::*;
(
  input  wire logic        clk_i,               // System clock
  input  wire logic        rst_n_i,             // Synchronous reset
  input  wire logic [1:0]  avs_address_i,       // Word address
  input  wire logic        avs_read_i,          // Read request
  input  wire logic        avs_write_i,         // Write request
  input  wire logic [31:0] avs_writedata_i,     // Write data
  output logic      [31:0] avs_readdata_o,      // Read data
  output logic             avs_waitrequest_o,   // Stall
  pic_if.cpu               bus                  // Controller side
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pic_state_t  fsm;      // Access sequencer
    logic        wait_r;   // Waitrequest
    logic [31:0] rdata;    // Avalon read data
    logic [7:0]  addr;     // Byte offset driven out
    logic [7:0]  wdata;    // Byte driven out
    logic        wr;       // Byte write strobe
    logic        rd;       // Byte read strobe
    logic        acc;      // Accept pulse
    logic        swi;      // Software trap pulse
    logic        rti;      // Maskable return pulse
    logic        rtn;      // Non-maskable return pulse
    logic        rtn_gie;  // Popped enable
  } pic_cpu_t;

  pic_cpu_t st_reg;  // Registered state
  pic_cpu_t st_next; // Next state

  // ----------------------------------------------------------------
  // Sequencer: every access ends in one low-waitrequest cycle
  // ----------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.wait_r = 1'b1;
    st_next.wr     = 1'b0;
    st_next.rd     = 1'b0;
    st_next.acc    = 1'b0;
    st_next.swi    = 1'b0;
    st_next.rti    = 1'b0;
    st_next.rtn    = 1'b0;
    case (st_reg.fsm)
      PIC_IDLE: begin
        if (avs_write_i) begin
          st_next.fsm    = PIC_DONE;
          st_next.wait_r = 1'b0;
          case (avs_address_i)
            PIC_AV_SFR: begin
              st_next.addr  = avs_writedata_i[15:8];
              st_next.wdata = avs_writedata_i[7:0];
              // Plain byte loads only, so no request is lost
              if (avs_writedata_i[PIC_SFR_RD]) begin
                st_next.rd     = 1'b1;
                st_next.fsm    = PIC_BUSY;
                st_next.wait_r = 1'b1;
              end else begin
                st_next.wr = 1'b1;
              end
            end
            PIC_AV_CPU: begin
              // Accept only what is presented right now
              st_next.acc = avs_writedata_i[PIC_CPU_ACC] & bus.irq_req;
              st_next.rti = avs_writedata_i[PIC_CPU_RTI];
              st_next.rtn = avs_writedata_i[PIC_CPU_RTN];
              st_next.swi = avs_writedata_i[PIC_CPU_SWI];
              st_next.rtn_gie = avs_writedata_i[PIC_CPU_GIE];
            end
            default: begin
              st_next.fsm = PIC_DONE; // Unmapped write ignored
            end
          endcase
        end else if (avs_read_i) begin
          st_next.fsm    = PIC_DONE;
          st_next.wait_r = 1'b0;
          case (avs_address_i)
            PIC_AV_SFR:  st_next.rdata = {24'h000000, st_reg.wdata};
            PIC_AV_STAT: st_next.rdata = {4'h0, bus.irq_vec,
                                          bus.saved_gie, bus.irq_src,
                                          bus.irq_req};
            default:     st_next.rdata = 32'h00000000;
          endcase
        end
      end
      PIC_BUSY: begin
        // Wait for the byte; keep it in the write-data holder
        if (bus.sfr_rvalid) begin
          st_next.wdata  = bus.sfr_rdata;
          st_next.rdata  = {24'h000000, bus.sfr_rdata};
          st_next.fsm    = PIC_DONE;
          st_next.wait_r = 1'b0;
        end
      end
      PIC_DONE: begin
        st_next.fsm = PIC_IDLE; // Master releases after this edge
      end
      default: begin
        st_next.fsm = PIC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg        <= '0;
      st_reg.fsm    <= PIC_IDLE;
      st_reg.wait_r <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from state
  // ----------------------------------------------------------------
  assign avs_readdata_o    = st_reg.rdata;
  assign avs_waitrequest_o = st_reg.wait_r;
  assign bus.sfr_addr      = st_reg.addr;
  assign bus.sfr_wdata     = st_reg.wdata;
  assign bus.sfr_wr        = st_reg.wr;
  assign bus.sfr_rd        = st_reg.rd;
  assign bus.accept        = st_reg.acc;
  assign bus.swi_take      = st_reg.swi;
  assign bus.ret_mask      = st_reg.rti;
  assign bus.ret_nmi       = st_reg.rtn;
  assign bus.ret_nmi_gie   = st_reg.rtn_gie;

endmodule : pic_cpu
`default_nettype wire

// ---- pic_chk.sv ----
// Concurrent checks on the link between controller and CPU end
`timescale 1ns/1ps
`default_nettype none
module pic_chk
  import pic_pkg::*;
(
  input  wire logic        clk_i,      // System clock
  input  wire logic        rst_n_i,    // Synchronous reset
  input  wire logic        sfr_rd,     // Byte read strobe
  input  wire logic        sfr_rvalid, // Read byte valid
  input  wire logic        irq_req,    // Source awaits acceptance
  input  wire logic [5:0]  irq_src,    // Winning source
  input  wire logic [19:0] irq_vec,    // Winning vector
  input  wire logic        accept      // CPU takes the source
);
  // ----------------------------------------------------------------
  // Link rules
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Every byte read is answered one cycle later
  a_read_answered: assert property (sfr_rd |=> sfr_rvalid)
    else $error("byte read not answered");
  // A valid byte only follows a read strobe
  a_valid_has_cause: assert property (sfr_rvalid |-> $past(sfr_rd))
    else $error("read valid without read");
  // Acceptance withdraws the request at once
  a_accept_drops: assert property (accept && irq_req |=> !irq_req)
    else $error("request stays after accept");
  // Entry masks maskable sources; only the watchdog may follow
  a_entry_masks: assert property (accept && irq_req |=> ##1
    (!irq_req || irq_src == PIC_SRC_WDT))
    else $error("maskable request right after entry");
  // Upper table steps down four per level
  a_vec_upper: assert property (irq_req && irq_src < 6'h20 |->
    irq_vec == PIC_VEC_HIGH - {12'h0, irq_src, 2'h0})
    else $error("upper vector wrong");
  // Lower table restarts at its own base
  a_vec_lower: assert property (irq_req && irq_src >= 6'h20 |->
    irq_vec == PIC_VEC_LOW - {12'h0, irq_src - 6'h20, 2'h0})
    else $error("lower vector wrong");
  // Reserved positions never win
  a_no_reserved: assert property (irq_req |-> PIC_SRC_MASK[irq_src])
    else $error("reserved source presented");
  // Nothing is pending right out of reset
  a_reset_quiet: assert property ($rose(rst_n_i) |-> !irq_req)
    else $error("request right after reset");

  // Main scenarios reached
  c_accept: cover property (accept && irq_req);
  c_read:   cover property (sfr_rvalid);
  c_wdt:    cover property (irq_req && irq_src == PIC_SRC_WDT);
endmodule : pic_chk
`default_nettype wire

// ---- test_prioritized_interrupt_controller.sv ----
// Self-checking bench: CPU end and controller joined by the link
`timescale 1ns/1ps
`default_nettype none
module test_prioritized_interrupt_controller;
  import pic_pkg::*;
  logic        clk_i;            // System clock
  logic        rst_n_i;          // Synchronous reset
  logic [47:0] src_evt;          // Peripheral pulses
  logic        wdt_evt;          // Watchdog pulse
  logic        pin;              // External pin
  logic        wdt_rst;          // Watchdog reset request
  logic        wdt_seen = 1'b0;  // Reset request ever pulsed
  logic [1:0]  av_a;             // Avalon address
  logic        av_rd;            // Avalon read
  logic        av_wr;            // Avalon write
  logic [31:0] av_wd;            // Avalon write data
  logic [31:0] av_q;             // Avalon read data
  logic        av_wait;          // Avalon stall
  logic [31:0] q;                // Last answer taken
  int          error_cnt = 0;    // Mismatches
  int          checks = 0;       // Comparisons
  int          cyc = 0;          // Cycle count for the hang limit

  pic_if pic_if_i ();
  pic_dev pic_dev_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .src_evt_i(src_evt),
    .watchdog_irq_i(wdt_evt), .external_pin_irq_i(pin),
    .wdt_reset_req_o(wdt_rst), .bus(pic_if_i));
  pic_cpu pic_cpu_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(av_a),
    .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wd),
    .avs_readdata_o(av_q), .avs_waitrequest_o(av_wait), .bus(pic_if_i));
  pic_chk pic_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sfr_rd(pic_if_i.sfr_rd), .sfr_rvalid(pic_if_i.sfr_rvalid),
    .irq_req(pic_if_i.irq_req), .irq_src(pic_if_i.irq_src),
    .irq_vec(pic_if_i.irq_vec), .accept(pic_if_i.accept));

  // ----------------------------------------------------------------
  // Clock, hang limit and helpers
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Pulse is one cycle wide, so latch it for a later look
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (wdt_rst === 1'b1) wdt_seen <= 1'b1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s: expected %h seen %h", n, e, s);
    end
  endtask
  // One Avalon access; held until waitrequest is sampled low
  task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    av_wr <= w;
    av_rd <= !w;
    av_a <= a;
    av_wd <= d;
    @(posedge clk_i);
    while (av_wait !== 1'b0) @(posedge clk_i);
    q = av_q;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask
  task automatic put(input logic [7:0] o, d);
    av(1'b1, PIC_AV_SFR, {16'h0, o, d});
  endtask
  // Byte read leaves the byte in q
  task automatic get(input logic [7:0] o);
    av(1'b1, PIC_AV_SFR, {15'h0, 1'b1, o, 8'h0});
    av(1'b0, PIC_AV_SFR, 32'h0);
    q = {24'h0, q[7:0]};
  endtask
  task automatic cpu(input logic [4:0] c);
    av(1'b1, PIC_AV_CPU, {27'h0, c});
  endtask
  function automatic logic [19:0] vec(input logic [5:0] s);
    if (s < 6'h20) return 20'hffffc - {12'h0, s, 2'h0};
    return 20'hfff3c - {12'h0, s - 6'h20, 2'h0};
  endfunction
  // Status word; saved enable bit is not judged here
  task automatic stat(input logic r, input logic [5:0] s);
    av(1'b0, PIC_AV_STAT, 32'h0);
    if (r) chk("status", q & 32'h0fff_ff7f, {4'h0, vec(s), 1'b0, s, 1'b1});
    else chk("request", {31'h0, q[0]}, 32'h0);
  endtask
  task automatic evt(input logic [47:0] m, input logic w);
    @(posedge clk_i);
    src_evt <= m;
    wdt_evt <= w;
    @(posedge clk_i);
    src_evt <= '0;
    wdt_evt <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    get(PIC_A_IL0);
    chk("latch0", q, 32'h0);
    get(PIC_A_EF0);
    chk("enable0", q, 32'h0);
    get(PIC_A_CTL);
    chk("control", q, 32'h2);
    stat(1'b0, 6'h0);
    av(1'b0, 2'h3, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask
  // Two requests at once: lower number first, other after return
  task automatic t_prio();
    put(PIC_A_EF1, 8'h01);
    put(PIC_A_EF4, 8'h04);
    put(PIC_A_EF0, 8'h01);
    evt(48'h0004_0000_0100, 1'b0);
    stat(1'b1, 6'h08);
    cpu(5'h01);
    stat(1'b0, 6'h0);
    chk("saved enable", {31'h0, q[7]}, 32'h1);
    get(PIC_A_IL1);
    chk("latch1", q, 32'h0);
    get(PIC_A_IL4);
    chk("latch4", q, 32'h4);
    cpu(5'h02);
    stat(1'b1, 6'h22);
  endtask
  // Ones never set, a zero clears one latch; own enable masks
  task automatic t_latch();
    put(PIC_A_EF0, 8'h00);
    put(PIC_A_IL4, 8'hff);
    get(PIC_A_IL4);
    chk("latch4 ones", q, 32'h4);
    put(PIC_A_IL4, 8'hfb);
    get(PIC_A_IL4);
    chk("latch4 zero", q, 32'h0);
    put(PIC_A_EF4, 8'h00);
    put(PIC_A_EF0, 8'h01);
    evt(48'h0004_0000_0000, 1'b0);
    stat(1'b0, 6'h0);
    put(PIC_A_EF0, 8'h00);
    put(PIC_A_IL4, 8'h00);
  endtask
  // Pin needs its own enable; then nesting count and clear
  task automatic t_pin();
    put(PIC_A_EF0, 8'h09);
    pin <= 1'b1;
    repeat (5) @(posedge clk_i);
    stat(1'b0, 6'h0);
    put(PIC_A_CTL, 8'h03);
    stat(1'b1, 6'h03);
    cpu(5'h01);
    get(PIC_A_CTL);
    chk("nesting one", q, 32'h13);
    put(PIC_A_CTL, 8'h11);
    get(PIC_A_CTL);
    chk("nesting clear", q, 32'h01);
  endtask
  // Watchdog ignores the cleared global enable; select 1 resets
  task automatic t_wdt();
    evt(48'h40, 1'b1);
    stat(1'b1, PIC_SRC_WDT);
    chk("no reset request", {31'h0, wdt_seen}, 32'h0);
    put(PIC_A_IL0, 8'h0c);
    get(PIC_A_IL0);
    chk("latch0 kept", q, 32'h4);
    cpu(5'h01);
    cpu(5'h0c);
    get(PIC_A_EF0);
    chk("enable popped", q, 32'h9);
    cpu(5'h10);
    stat(1'b0, 6'h0);
    chk("trap saved", {31'h0, q[7]}, 32'h1);
    put(PIC_A_CTL, 8'h03);
    evt(48'h0, 1'b1);
    chk("reset request", {31'h0, wdt_seen}, 32'h1);
    stat(1'b0, 6'h0);
  endtask

  initial begin
    rst_n_i = 1'b0;
    src_evt = '0;
    wdt_evt = 1'b0;
    pin = 1'b0;
    av_a = 2'h0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wd = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_prio();
    t_latch();
    t_pin();
    t_wdt();
    wrap_up();
  end
endmodule : test_prioritized_interrupt_controller
`default_nettype wire
